// *** common/fsr2_map.svh ***
// Offsets, field positions, reset values and opcodes of the second status register
`ifndef FSR2_MAP_SVH
`define FSR2_MAP_SVH

// ****************************************************************
// Register fields
// ****************************************************************
`define FSR2_BIT_SUSPEND 7
`define FSR2_BIT_INVERT 6
`define FSR2_BIT_LOCK_HI 5
`define FSR2_BIT_LOCK_LO 3
`define FSR2_BIT_RSVD 2
`define FSR2_BIT_QUAD 1
`define FSR2_BIT_GUARD_HI 0
`define FSR2_RESET_VALUE 8'h00
`define FSR2_LOCK_RESET 3'h0

// ****************************************************************
// Command opcodes
// ****************************************************************
`define FSR2_OP_READ 8'h35
`define FSR2_OP_WRITE 8'h31
`define FSR2_OP_SUSPEND 8'h75
`define FSR2_OP_RESUME 8'h7A
`define FSR2_OP_RST_EN 8'h66
`define FSR2_OP_RST 8'h99
`define FSR2_OP_QUAD_OUT_RD 8'h6B
`define FSR2_OP_XIP_RD 8'hEB
`define FSR2_OP_QUAD_ALN_RD 8'hE7
`define FSR2_OP_QUAD_PROG 8'h32
`define FSR2_OP_BURST_WRAP 8'h77
`define FSR2_OP_QUAD_ID 8'h94

// ****************************************************************
// Protection geometry
// ****************************************************************
`define FSR2_SHIFT_64K 5'h10
`define FSR2_SHIFT_4K 5'h0C
`define FSR2_ARRAY_BYTES 23'h400000
`define FSR2_OTP_LAST_BYTE 7'h7F

`endif

// *** common/fsr2_pkg.sv ***
// Types shared by the second status register block
package fsr2_pkg;
  typedef enum logic [2:0] {
    FSR2_WAIT_OP = 3'b001,
    FSR2_WAIT_DATA = 3'b010,
    FSR2_EXTRA = 3'b100
  } fsr2_frame_t;
endpackage

// *** core/fsr2_status.sv ***
// Second status register: suspend, security locks, protect invert and quad enable
`timescale 1ns/1ps
`include "fsr2_map.svh"

// Overview of operation
// - Suspend command sets suspend flag
// - Resume, hardware or software reset clears suspend
// - Suspend flag read-only, resets to zero
// - Invert bit swaps protected and unprotected regions
// - Invert combined with granule, direction, extent
// - Lock flags of registers 3..1 in bits 5..3
// - Last byte programmed sets its lock flag
// - Locked security register refuses further programming
// - Security register zero always locked
// - Lock flags of registers 3..1 reset to zero
// - Quad enable gates quad modes, resets zero
// - Quad off: guard and pause pins control
// - Quad on: guard and pause pins carry data
// - Quad enable affects only listed quad commands
// - Write needs permit latch and guard high bit clear; guard low bit blocks it only with the write-guard pin low and quad off
module fsr2_status (
  input wire logic ref_clk_i, // Core clock, 250 MHz
  input wire logic rst_i, // Asynchronous reset, active high
  input wire logic spi_clk_i, // Serial clock from the host
  input wire logic spi_cs_n_i, // Chip select, active low
  input wire logic spi_mosi_i, // Serial data in
  output logic spi_miso_o, // Serial data out
  input wire logic wr_guard_n_i, // Write-guard pin, active low
  input wire logic pause_rst_n_i, // Pause-or-reset pin, active low
  input wire logic write_permit_latch_i, // Write permit latch state
  input wire logic status_guard_high_i, // Status guard, high bit
  input wire logic status_guard_low_i, // Status guard, low bit
  input wire logic jedec_reset_i, // JEDEC reset detected, pulse
  input wire logic [21:0] prog_addr_i, // Address to check for protection
  input wire logic protect_granule_i, // 1: 4 KB units, 0: 64 KB units
  input wire logic protect_direction_i, // 1: from top, 0: from bottom
  input wire logic [2:0] protect_extent_i, // Protected extent code
  input wire logic otp_prog_req_i, // Security register program request
  input wire logic [1:0] otp_sel_i, // Security register index
  input wire logic [6:0] otp_byte_i, // Byte index within register
  output logic [7:0] status_o, // Register value
  output logic protect_invert_o, // Protect invert bit
  output logic quad_io_enable_o, // Quad enable bit
  output logic [3:0] otp_lock_flags_o, // Lock state of registers 3..0
  output logic wr_protected_o, // Address is write protected
  output logic otp_prog_grant_o, // Program accepted, pulse
  output logic otp_prog_refused_o, // Program refused, pulse
  output logic quad_cmd_ok_o, // Current opcode may run in quad mode
  output logic guard_func_o, // Write-guard pin acts as control
  output logic pause_func_o, // Pause-or-reset pin acts as control
  output logic write_accepted_o // Register write committed, pulse
);

  // ****************************************************************
  // Serial clock domain
  // ****************************************************************
  logic frame_rst;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [6:0] shift_q, shift_d;
  logic first_q, first_d;
  logic rd_mode_q, rd_mode_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] byte_q, byte_d;
  logic byte_tgl_q, byte_tgl_d;
  logic miso_q;
  logic [7:0] snap_q, snap_d;

  // Chip select high parks the frame logic, since the clock stops between frames
  assign frame_rst = rst_i | spi_cs_n_i;

  always_comb begin
    bit_cnt_d = bit_cnt_q + 3'h1;
    shift_d = {shift_q[5:0], spi_mosi_i};
    first_d = first_q;
    rd_mode_d = rd_mode_q;
    tx_d = rd_mode_q ? {tx_q[6:0], tx_q[7]} : tx_q;
    if (bit_cnt_q == 3'h7) begin
      first_d = 1'b0;
      if (first_q && {shift_q, spi_mosi_i} == `FSR2_OP_READ) begin
        rd_mode_d = 1'b1;
        // Snapshot is frozen while the frame is open, so the word is steady here
        tx_d = snap_q;
      end
    end
  end

  always_ff @(posedge spi_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      first_q <= 1'b1;
      rd_mode_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      first_q <= first_d;
      rd_mode_q <= rd_mode_d;
      tx_q <= tx_d;
    end
  end

  // Byte hand-off: data stays put for a whole byte time after each toggle
  always_comb begin
    byte_d = byte_q;
    byte_tgl_d = byte_tgl_q;
    if (bit_cnt_q == 3'h7) begin
      byte_d = {shift_q, spi_mosi_i};
      byte_tgl_d = ~byte_tgl_q;
    end
  end

  always_ff @(posedge spi_clk_i or posedge rst_i) begin
    if (rst_i) begin
      byte_q <= 8'h00;
      byte_tgl_q <= 1'b0;
    end else begin
      byte_q <= byte_d;
      byte_tgl_q <= byte_tgl_d;
    end
  end

  always_ff @(negedge spi_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= tx_q[7];
    end
  end

  assign spi_miso_o = miso_q;

  // ****************************************************************
  // Synchronisers into the core clock
  // ****************************************************************
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic wg_s1_q, wg_s2_q, pr_s1_q, pr_s2_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      wg_s1_q <= 1'b1;
      wg_s2_q <= 1'b1;
      pr_s1_q <= 1'b1;
      pr_s2_q <= 1'b1;
    end else begin
      cs_s1_q <= spi_cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tgl_s1_q <= byte_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      wg_s1_q <= wr_guard_n_i;
      wg_s2_q <= wg_s1_q;
      pr_s1_q <= pause_rst_n_i;
      pr_s2_q <= pr_s1_q;
    end
  end

  // ****************************************************************
  // Command framing and register state
  // ****************************************************************
  fsr2_pkg::fsr2_frame_t frame_q, frame_d;
  logic [7:0] op_q, op_d, data_q, data_d;
  logic have_op_q, have_op_d, have_data_q, have_data_d;
  logic suspend_flag_q, suspend_flag_d, inv_q, inv_d, quad_q, quad_d, rst_en_q, rst_en_d;
  logic wr_acc_q, wr_acc_d;
  logic byte_evt, cs_rise, hw_rst, sw_rst, wr_ok, is_quad_op;

  assign byte_evt = tgl_s2_q ^ tgl_s3_q;
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  // With quad on the pin is a data line and its reset is ignored
  assign hw_rst = ~quad_q & ~pr_s2_q;
  assign sw_rst = cs_rise & have_op_q & (op_q == `FSR2_OP_RST) & rst_en_q;
  assign wr_ok = write_permit_latch_i & ~status_guard_high_i
    & (~status_guard_low_i | quad_q | wg_s2_q);

  always_comb begin
    unique case (op_q)
      `FSR2_OP_QUAD_OUT_RD, `FSR2_OP_XIP_RD, `FSR2_OP_QUAD_ALN_RD, `FSR2_OP_QUAD_PROG,
      `FSR2_OP_BURST_WRAP, `FSR2_OP_QUAD_ID: is_quad_op = 1'b1;
      default: is_quad_op = 1'b0;
    endcase
  end

  always_comb begin
    frame_d = frame_q;
    op_d = op_q;
    data_d = data_q;
    have_op_d = have_op_q;
    have_data_d = have_data_q;
    if (cs_s2_q) begin
      frame_d = fsr2_pkg::FSR2_WAIT_OP;
      have_op_d = 1'b0;
      have_data_d = 1'b0;
    end else if (byte_evt) begin
      unique case (frame_q)
        fsr2_pkg::FSR2_WAIT_OP: begin
          op_d = byte_q;
          have_op_d = 1'b1;
          frame_d = fsr2_pkg::FSR2_WAIT_DATA;
        end
        fsr2_pkg::FSR2_WAIT_DATA: begin
          data_d = byte_q;
          have_data_d = 1'b1;
          frame_d = fsr2_pkg::FSR2_EXTRA;
        end
        fsr2_pkg::FSR2_EXTRA: frame_d = fsr2_pkg::FSR2_EXTRA;
      endcase
    end
  end

  always_comb begin
    suspend_flag_d = suspend_flag_q;
    inv_d = inv_q;
    quad_d = quad_q;
    rst_en_d = rst_en_q;
    wr_acc_d = 1'b0;
    // Clears first, so a suspend in the same cycle wins
    if (hw_rst || jedec_reset_i || sw_rst) begin
      suspend_flag_d = 1'b0;
      rst_en_d = 1'b0;
    end
    if (cs_rise && have_op_q) begin
      rst_en_d = (op_q == `FSR2_OP_RST_EN) & ~hw_rst & ~jedec_reset_i;
      if (op_q == `FSR2_OP_RESUME) begin
        suspend_flag_d = 1'b0;
      end
      if (op_q == `FSR2_OP_SUSPEND) begin
        suspend_flag_d = 1'b1;
      end
      if (op_q == `FSR2_OP_WRITE && have_data_q && wr_ok) begin
        // Suspend, lock and reserved bits of the data byte are dropped
        inv_d = data_q[`FSR2_BIT_INVERT];
        quad_d = data_q[`FSR2_BIT_QUAD];
        wr_acc_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_q <= fsr2_pkg::FSR2_WAIT_OP;
      op_q <= 8'h00;
      data_q <= 8'h00;
      have_op_q <= 1'b0;
      have_data_q <= 1'b0;
      suspend_flag_q <= 1'b0;
      inv_q <= 1'b0;
      quad_q <= 1'b0;
      rst_en_q <= 1'b0;
      wr_acc_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      op_q <= op_d;
      data_q <= data_d;
      have_op_q <= have_op_d;
      have_data_q <= have_data_d;
      suspend_flag_q <= suspend_flag_d;
      inv_q <= inv_d;
      quad_q <= quad_d;
      rst_en_q <= rst_en_d;
      wr_acc_q <= wr_acc_d;
    end
  end

  // ****************************************************************
  // Security register locks
  // ****************************************************************
  logic [2:0] lock_q, lock_d;
  logic sel_locked, grant;

  // Index zero is factory data and always counts as locked
  assign sel_locked = (otp_sel_i == 2'h0) | lock_q[otp_sel_i - 2'h1];
  assign grant = otp_prog_req_i & ~sel_locked;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_lock
      always_comb begin
        lock_d[gi] = lock_q[gi] | (grant && otp_sel_i == 2'(gi + 1)
          && otp_byte_i == `FSR2_OTP_LAST_BYTE);
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q <= `FSR2_LOCK_RESET;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ****************************************************************
  // Protection check and registered outputs
  // ****************************************************************
  logic [22:0] span;
  logic [22:0] addr_x;
  logic base_prot, prot_d;
  logic [4:0] unit_shift;
  logic [7:0] stat_d;
  logic [7:0] stat_q;
  logic prot_q, grant_q, refused_q, qok_q, gfun_q, pfun_q;
  logic [3:0] lockf_q;

  always_comb begin
    unit_shift = protect_granule_i ? `FSR2_SHIFT_4K : `FSR2_SHIFT_64K;
    span = 23'h1 << (unit_shift + 5'(protect_extent_i) - 5'h1);
    addr_x = {1'b0, prog_addr_i};
    if (protect_extent_i == 3'h0) begin
      base_prot = 1'b0;
    end else if (protect_extent_i == 3'h7) begin
      base_prot = 1'b1;
    end else if (protect_direction_i) begin
      base_prot = addr_x >= (`FSR2_ARRAY_BYTES - span);
    end else begin
      base_prot = addr_x < span;
    end
    prot_d = base_prot ^ inv_q;
    stat_d = {suspend_flag_q, inv_q, lock_q, 1'b0, quad_q, status_guard_high_i};
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= `FSR2_RESET_VALUE;
      snap_q <= `FSR2_RESET_VALUE;
      prot_q <= 1'b0;
      grant_q <= 1'b0;
      refused_q <= 1'b0;
      qok_q <= 1'b0;
      gfun_q <= 1'b1;
      pfun_q <= 1'b1;
      lockf_q <= 4'h1;
    end else begin
      stat_q <= stat_d;
      snap_q <= snap_d;
      prot_q <= prot_d;
      grant_q <= grant;
      refused_q <= otp_prog_req_i & sel_locked;
      qok_q <= quad_q & have_op_q & is_quad_op;
      gfun_q <= ~quad_q;
      pfun_q <= ~quad_q;
      lockf_q <= {lock_q, 1'b1};
    end
  end

  // Snapshot follows the register only between frames
  assign snap_d = cs_s2_q ? stat_d : snap_q;

  assign status_o = stat_q;
  assign protect_invert_o = stat_q[`FSR2_BIT_INVERT];
  assign quad_io_enable_o = stat_q[`FSR2_BIT_QUAD];
  assign otp_lock_flags_o = lockf_q;
  assign wr_protected_o = prot_q;
  assign otp_prog_grant_o = grant_q;
  assign otp_prog_refused_o = refused_q;
  assign quad_cmd_ok_o = qok_q;
  assign guard_func_o = gfun_q;
  assign pause_func_o = pfun_q;
  assign write_accepted_o = wr_acc_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_suspend_flag_set;
    @(posedge ref_clk_i) disable iff (rst_i)
      cs_rise && have_op_q && op_q == `FSR2_OP_SUSPEND |=> suspend_flag_q ##1 status_o[7];
  endproperty
  a_suspend_flag_set: assert property (p_suspend_flag_set) else $error("suspend not set");

  property p_resume;
    @(posedge ref_clk_i) disable iff (rst_i)
      cs_rise && have_op_q && op_q == `FSR2_OP_RESUME |=> !suspend_flag_q;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not clear");

  property p_suspend_flag_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      !cs_rise && !hw_rst && !jedec_reset_i |=> $stable(suspend_flag_q);
  endproperty
  a_suspend_flag_hold: assert property (p_suspend_flag_hold) else $error("suspend moved");

  property p_invert_all;
    @(posedge ref_clk_i) disable iff (rst_i)
      protect_extent_i == 3'h0 && inv_q |=> wr_protected_o;
  endproperty
  a_invert_all: assert property (p_invert_all) else $error("invert ignored");

  property p_lock_refuse;
    @(posedge ref_clk_i) disable iff (rst_i)
      otp_prog_req_i && otp_sel_i != 2'h0 && lock_q[otp_sel_i - 2'h1]
      |=> !otp_prog_grant_o && otp_prog_refused_o;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked reg programmed");

  property p_zero_locked;
    @(posedge ref_clk_i) disable iff (rst_i)
      otp_prog_req_i && otp_sel_i == 2'h0 |=> otp_prog_refused_o ##1 otp_lock_flags_o[0];
  endproperty
  a_zero_locked: assert property (p_zero_locked) else $error("register zero open");

  property p_lock_set;
    @(posedge ref_clk_i) disable iff (rst_i)
      grant && otp_byte_i == `FSR2_OTP_LAST_BYTE
      |=> ##1 otp_lock_flags_o[$past(otp_sel_i, 2)] == 1'b1;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  property p_rsvd;
    @(posedge ref_clk_i) disable iff (rst_i) status_o[`FSR2_BIT_RSVD] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

  property p_no_perm;
    @(posedge ref_clk_i) disable iff (rst_i)
      cs_rise && !write_permit_latch_i |=> !write_accepted_o && $stable(quad_q);
  endproperty
  a_no_perm: assert property (p_no_perm) else $error("write without permit");

  property p_quad_gate;
    @(posedge ref_clk_i) disable iff (rst_i) !quad_q ##1 !quad_q |-> !quad_cmd_ok_o;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad without enable");

  property p_pin_func;
    @(posedge ref_clk_i) disable iff (rst_i) quad_q |=> !pause_func_o && !guard_func_o;
  endproperty
  a_pin_func: assert property (p_pin_func) else $error("pin control active");

  property p_locks_kept;
    @(posedge ref_clk_i) disable iff (rst_i) write_accepted_o |-> $stable(lock_q);
  endproperty
  a_locks_kept: assert property (p_locks_kept) else $error("write moved locks");

  c_write: cover property (@(posedge ref_clk_i) disable iff (rst_i) write_accepted_o);
  c_suspend: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(suspend_flag_q));
  c_lock: cover property (@(posedge ref_clk_i) disable iff (rst_i) $rose(lock_q[2]));
  c_quad: cover property (@(posedge ref_clk_i) disable iff (rst_i) quad_cmd_ok_o);

endmodule // fsr2_status

// *** dv/fsr2_spi_host.sv ***
// Serial host model that issues status register commands in mode 0
`timescale 1ns/1ps
module fsr2_spi_host #(
  parameter real HALF = 62.5
) (
  output logic spi_clk_o, // Serial clock, still between frames
  output logic spi_cs_n_o, // Chip select, active low
  output logic spi_mosi_o, // Serial data to the device
  input wire logic spi_miso_i // Serial data from the device
);
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // ****************************************************************
  // One frame: opcode, then an optional second byte; byte 1 is read back
  // ****************************************************************
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int nbytes,
                       output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    rd = 8'h00;
    spi_cs_n_o = 1'b0;
    for (int i = 0; i < 8 * nbytes; i++) begin
      spi_mosi_o = sh[15 - i];
      #(HALF);
      spi_clk_o = 1'b1;
      if (i >= 8) begin
        rd = {rd[6:0], spi_miso_i};
      end
      #(HALF);
      spi_clk_o = 1'b0;
    end
    // Margin before chip select rises, then the gap between frames
    #60;
    spi_cs_n_o = 1'b1;
    // A released line must not keep showing the last bit
    spi_mosi_o = ~spi_mosi_o;
    #100;
  endtask
endmodule // fsr2_spi_host

// *** dv/fsr2_status_tb_top.sv ***
// Self-checking testbench of the second status register block
`timescale 1ns/1ps
`include "fsr2_map.svh"
module fsr2_status_tb_top;
  logic ref_clk_i, rst_i, spi_clk, spi_cs_n, spi_mosi, spi_miso;
  logic wr_guard_n, pause_rst_n, wpl, sg_hi, sg_lo, jrst, gran, dir, req;
  logic [21:0] addr;
  logic [2:0] ext;
  logic [1:0] sel;
  logic [6:0] byt;
  logic [7:0] status, rd;
  logic [3:0] locks;
  logic inv, quad, wprot, grant, refused, qok, gfunc, pfunc, wacc;
  int fail_count = 0;
  int checks = 0;
  int wacc_n = 0;
  logic [26:0] pcase [6] = '{{1'b0, 1'b0, 3'h1, 22'h000000}, {1'b0, 1'b0, 3'h1, 22'h010000},
    {1'b1, 1'b1, 3'h2, 22'h3FE000}, {1'b1, 1'b1, 3'h2, 22'h3FDFFF},
    {1'b0, 1'b0, 3'h7, 22'h123456}, {1'b0, 1'b0, 3'h0, 22'h000000}};
  logic [7:0] qop [7] = '{8'h6B, 8'hEB, 8'hE7, 8'h32, 8'h77, 8'h94, 8'h03};

  fsr2_spi_host i_host (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
    .spi_miso_i(spi_miso));

  fsr2_status i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
    .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
    .wr_guard_n_i(wr_guard_n), .pause_rst_n_i(pause_rst_n), .write_permit_latch_i(wpl),
    .status_guard_high_i(sg_hi), .status_guard_low_i(sg_lo), .jedec_reset_i(jrst),
    .prog_addr_i(addr), .protect_granule_i(gran), .protect_direction_i(dir),
    .protect_extent_i(ext), .otp_prog_req_i(req), .otp_sel_i(sel), .otp_byte_i(byt),
    .status_o(status), .protect_invert_o(inv), .quad_io_enable_o(quad),
    .otp_lock_flags_o(locks), .wr_protected_o(wprot), .otp_prog_grant_o(grant),
    .otp_prog_refused_o(refused), .quad_cmd_ok_o(qok), .guard_func_o(gfunc),
    .pause_func_o(pfunc), .write_accepted_o(wacc));

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Counts accepted-write strobes, so a one-cycle pulse is never missed
  always @(posedge ref_clk_i) begin
    if (wacc === 1'b1) begin
      wacc_n <= wacc_n + 1;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // Frame then a few core cycles; the frame's own trailing gap covers the sync delay
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input int nb);
    i_host.frame(op, dat, nb, rd);
    cyc(2);
  endtask

  // Sample the quad flag mid-frame, once the opcode has crossed over
  task automatic qprobe(input logic [7:0] op, input logic exp);
    fork
      i_host.frame(op, 8'h00, 2, rd);
      begin
        #1600;
        cyc(1);
        chk(qok, exp);
      end
    join
    cyc(2);
  endtask

  task automatic otp(input logic [1:0] s, input logic [6:0] b, input logic g);
    @(posedge ref_clk_i);
    req <= 1'b1;
    sel <= s;
    byt <= b;
    @(posedge ref_clk_i);
    req <= 1'b0;
    #1;
    chk(grant, g);
    chk(refused, !g);
    cyc(2);
  endtask

  function automatic logic prot(input logic [26:0] c, input logic v);
    logic [22:0] span;
    span = (c[26] ? 23'h001000 : 23'h010000) << (c[24:22] - 3'h1);
    if (c[24:22] == 3'h0) return v;
    if (c[24:22] == 3'h7) return !v;
    return (c[25] ? ({1'b0, c[21:0]} >= 23'h400000 - span) : ({1'b0, c[21:0]} < span)) ^ v;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    $display("Watchdog expired at %0t", $time);
    tally_and_finish();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {rst_i, wr_guard_n, pause_rst_n} = 3'h7;
    {wpl, sg_hi, sg_lo, jrst, gran, dir, req, ext, sel, byt, addr} = '0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cyc(4);
    chk(status, `FSR2_RESET_VALUE);
    chk(locks, 4'h1);
    chk({gfunc, pfunc, quad}, 8'h06);
    cmd(`FSR2_OP_WRITE, 8'h42, 2);
    chk(status, 8'h00);
    chk(wacc_n[7:0], 8'h00);
    @(posedge ref_clk_i) wpl <= 1'b1;
    cmd(`FSR2_OP_WRITE, 8'hFF, 2);
    chk(status, 8'h42);
    chk(wacc_n[7:0], 8'h01);
    chk({inv, quad, gfunc, pfunc}, 8'h0C);
    cmd(`FSR2_OP_READ, 8'h00, 2);
    chk(rd, 8'h42);
    foreach (qop[k]) qprobe(qop[k], k < 6);
    $display("test reset_write_quad done");
    @(posedge ref_clk_i) sg_hi <= 1'b1;
    cmd(`FSR2_OP_WRITE, 8'h00, 2);
    chk(status, 8'h43);
    @(posedge ref_clk_i) {sg_hi, sg_lo, wr_guard_n} <= 3'b010;
    cmd(`FSR2_OP_WRITE, 8'h00, 2);
    chk(status, 8'h00);
    cmd(`FSR2_OP_WRITE, 8'h02, 2);
    chk(status, 8'h00);
    chk({gfunc, pfunc}, 8'h03);
    @(posedge ref_clk_i) {sg_lo, wr_guard_n} <= 2'b01;
    qprobe(8'h6B, 1'b0);
    $display("test guard done");
    for (int v = 0; v < 2; v++) begin
      cmd(`FSR2_OP_WRITE, v ? 8'h40 : 8'h00, 2);
      foreach (pcase[k]) begin
        @(posedge ref_clk_i) {gran, dir, ext, addr} <= pcase[k];
        cyc(3);
        chk(wprot, prot(pcase[k], v[0]));
      end
    end
    $display("test protect done");
    cmd(`FSR2_OP_SUSPEND, 8'h00, 1);
    cmd(`FSR2_OP_WRITE, 8'h00, 2);
    chk(status, 8'h80);
    cmd(`FSR2_OP_RESUME, 8'h00, 1);
    chk(status[7], 1'b0);
    cmd(`FSR2_OP_SUSPEND, 8'h00, 1);
    cmd(`FSR2_OP_RST, 8'h00, 1);
    chk(status[7], 1'b1);
    cmd(`FSR2_OP_RST_EN, 8'h00, 1);
    cmd(`FSR2_OP_RST, 8'h00, 1);
    chk(status[7], 1'b0);
    cmd(`FSR2_OP_SUSPEND, 8'h00, 1);
    chk(status[7], 1'b1);
    @(posedge ref_clk_i) jrst <= 1'b1;
    @(posedge ref_clk_i) jrst <= 1'b0;
    cyc(3);
    chk(status[7], 1'b0);
    cmd(`FSR2_OP_SUSPEND, 8'h00, 1);
    chk(status[7], 1'b1);
    @(posedge ref_clk_i) pause_rst_n <= 1'b0;
    cyc(4);
    @(posedge ref_clk_i) pause_rst_n <= 1'b1;
    cyc(6);
    chk(status[7], 1'b0);
    $display("test suspend done");
    otp(2'h1, 7'h7E, 1'b1);
    chk(locks, 4'h1);
    otp(2'h1, `FSR2_OTP_LAST_BYTE, 1'b1);
    cyc(1);
    chk(locks, 4'h3);
    chk(status[5:3], 3'h1);
    otp(2'h1, 7'h00, 1'b0);
    otp(2'h0, 7'h00, 1'b0);
    otp(2'h3, `FSR2_OTP_LAST_BYTE, 1'b1);
    cyc(1);
    chk(locks, 4'hB);
    cmd(`FSR2_OP_WRITE, 8'hBE, 2);
    chk(status, 8'h2A);
    $display("test otp done");
    tally_and_finish();
  end
endmodule // fsr2_status_tb_top
